// ==== hw/dc7_params.svh ====
`ifndef DC7_PARAMS_SVH
`define DC7_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define JC_W 5
`define AXI_AW 8
`define NUM_PINS 6

// ----------------------------------------
// Pin input indices
// ----------------------------------------
`define PIN_CLK 0
`define PIN_INH 1
`define PIN_RST 2
`define PIN_GATE 3
`define PIN_RBI 4
`define PIN_TEST 5

// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SEGS 8'h08
`define CTRL_W 3
`define CTRL_RST 3'h0
`define CTRL_VAR_BIT 0
`define CTRL_INH_BIT 1
`define CTRL_CLR_BIT 2
`define ST_DIG_LSB 8
`define ST_CARRY_BIT 12
`define ST_SEG_LSB 16
`define SG_C_BIT 7
`define SG_GATE_BIT 8
`define SG_RBO_BIT 9
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// Counter codes and segment patterns
// ----------------------------------------
`define JC_ZERO 5'h00
`define JC_TOP_BIT 4
`define DIG_BAD 4'hf
`define SEG_C_IDX 2
`define SEG_OFF 7'h00
`define SEG_ALL 7'h7f
`define SEG_D0 7'h3f
`define SEG_D1 7'h06
`define SEG_D2 7'h5b
`define SEG_D3 7'h4f
`define SEG_D4 7'h66
`define SEG_D5 7'h6d
`define SEG_D6 7'h7d
`define SEG_D7 7'h07
`define SEG_D8 7'h7f
`define SEG_D9 7'h6f

`endif

// ==== hw/dc7_pkg.sv ====
package dc7_pkg;
  `include "dc7_params.svh"

  // ----------------------------------------
  // Register bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [`AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`AXI_AW-1:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  // ----------------------------------------
  // Whole block state
  // ----------------------------------------
  typedef struct packed {
    logic [`NUM_PINS-1:0] s1;
    logic [`NUM_PINS-1:0] s2;
    logic [`NUM_PINS-1:0] s3;
    logic [`NUM_PINS-1:0] filt;
    logic [`JC_W-1:0] john;
    logic [`CTRL_W-1:0] ctrl;
    logic aw_got;
    logic [`AXI_AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [6:0] seg;
    logic seg_c;
    logic gate_o;
    logic rbo;
    logic carry;
  } dc_state_t;
endpackage : dc7_pkg

// ==== hw/decade_counter_seven_segment.sv ====
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// R1: Reset high clears the count to zero
// R2: Count advances one per rising clock edge, inhibit low
// R3: Inhibit high holds the count
// R4: Five-stage Johnson counter, decoded to segments
// R5: Illegal Johnson states return to valid sequence
// R6: Carry completes one period per ten clocks
// R7: Segments active high show digit 0 to 9
// R8: Conventional patterns, a top, g middle
// R9: Gated variant: gate low forces segments low
// R10: Gated variant: carry and ungated c always live
// R11: Gated variant: gate output follows gate input
// R12: Ripple variant: zero with blank-in low blanks
// R13: Ripple variant: blank-in high shows zero
// R14: Blank-out low only while blanking a zero
// R15: Integer side chains blanking downward from top
// R16: Fraction side chains blanking upward from bottom
// R17: Ripple variant: segment test high lights all segments
// R18: Fully static, holds state without clock edges
`include "dc7_params.svh"

module decade_counter_seven_segment
  import dc7_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire axil_req_t axi_req_in,
  output axil_rsp_t axi_rsp_out,
  input wire logic count_clk_in,
  input wire logic count_inhibit_in,
  input wire logic count_reset_in,
  input wire logic display_gate_in,
  input wire logic ripple_blank_in,
  input wire logic segment_test_in,
  output logic [6:0] seg_out,
  output logic seg_c_ungated_out,
  output logic display_gate_out,
  output logic ripple_blank_out,
  output logic decade_carry_out
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Johnson code to digit, DIG_BAD for any illegal code
  function automatic logic [3:0] jc_digit(input logic [`JC_W-1:0] j);
    case (j)
      5'h00: jc_digit = 4'h0;
      5'h01: jc_digit = 4'h1;
      5'h03: jc_digit = 4'h2;
      5'h07: jc_digit = 4'h3;
      5'h0f: jc_digit = 4'h4;
      5'h1f: jc_digit = 4'h5;
      5'h1e: jc_digit = 4'h6;
      5'h1c: jc_digit = 4'h7;
      5'h18: jc_digit = 4'h8;
      5'h10: jc_digit = 4'h9;
      default: jc_digit = `DIG_BAD;
    endcase
  endfunction : jc_digit

  function automatic logic jc_legal(input logic [`JC_W-1:0] j);
    jc_legal = (jc_digit(j) != `DIG_BAD);
  endfunction : jc_legal

  // Twisted ring step: inverted top bit fed back into bit 0
  function automatic logic [`JC_W-1:0] jc_next(input logic [`JC_W-1:0] j);
    jc_next = {j[`JC_W-2:0], ~j[`JC_TOP_BIT]};
  endfunction : jc_next

  // Bit 0 is segment a, then clockwise, bit 6 is g
  function automatic logic [6:0] seg_of(input logic [`JC_W-1:0] j);
    case (jc_digit(j))
      4'h0: seg_of = `SEG_D0;
      4'h1: seg_of = `SEG_D1;
      4'h2: seg_of = `SEG_D2;
      4'h3: seg_of = `SEG_D3;
      4'h4: seg_of = `SEG_D4;
      4'h5: seg_of = `SEG_D5;
      4'h6: seg_of = `SEG_D6;
      4'h7: seg_of = `SEG_D7;
      4'h8: seg_of = `SEG_D8;
      4'h9: seg_of = `SEG_D9;
      default: seg_of = `SEG_OFF;
    endcase
  endfunction : seg_of

  dc_state_t q;
  dc_state_t d;
  logic [`NUM_PINS-1:0] pins;
  logic [`NUM_PINS-1:0] filt_d;
  logic cnt_edge;
  logic inh_eff;
  logic clr_eff;
  logic ripple_mode;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic [`AXI_AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [6:0] dec_d;
  logic zero_blank_d;

  // ----------------------------------------
  // Pin filtering and count qualifiers
  // ----------------------------------------
  assign pins = {segment_test_in, ripple_blank_in, display_gate_in,
                 count_reset_in, count_inhibit_in, count_clk_in};
  // A pin change counts only once stages two and three agree
  assign filt_d = (q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3));
  assign cnt_edge = filt_d[`PIN_CLK] & ~q.filt[`PIN_CLK];
  // Pin and register inhibits are ORed so either side can freeze
  assign inh_eff = filt_d[`PIN_INH] | q.ctrl[`CTRL_INH_BIT];
  assign clr_eff = filt_d[`PIN_RST] | q.ctrl[`CTRL_CLR_BIT];
  assign ripple_mode = q.ctrl[`CTRL_VAR_BIT];

  // ----------------------------------------
  // Register bus handshakes
  // ----------------------------------------
  // Address and data are taken in either order, one write at a time
  assign axi_rsp_out.awready = ~q.aw_got & ~q.bvalid;
  assign axi_rsp_out.wready = ~q.w_got & ~q.bvalid;
  assign axi_rsp_out.arready = ~q.rvalid;
  assign axi_rsp_out.bvalid = q.bvalid;
  assign axi_rsp_out.bresp = q.bresp;
  assign axi_rsp_out.rvalid = q.rvalid;
  assign axi_rsp_out.rdata = q.rdata;
  assign axi_rsp_out.rresp = q.rresp;
  assign aw_hs = axi_req_in.awvalid & axi_rsp_out.awready;
  assign w_hs = axi_req_in.wvalid & axi_rsp_out.wready;
  assign ar_hs = axi_req_in.arvalid & axi_rsp_out.arready;
  assign wr_fire = (q.aw_got | aw_hs) & (q.w_got | w_hs);
  assign wr_addr = q.aw_got ? q.aw_addr : axi_req_in.awaddr;
  assign wr_data = q.w_got ? q.w_data : axi_req_in.wdata;
  assign wr_strb = q.w_got ? q.w_strb : axi_req_in.wstrb;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.s1 = pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.filt = filt_d;

    // Counter core; clear beats everything, bad codes recover at once
    if (clr_eff) begin
      d.john = `JC_ZERO; // [R1]
    end else if (!jc_legal(q.john)) begin
      d.john = `JC_ZERO; // [R5]
    end else if (cnt_edge && !inh_eff) begin
      d.john = jc_next(q.john); // [R2] [R4]
    end else begin
      d.john = q.john; // [R3] [R18]
    end

    // Outputs follow the next count so they never lag the state
    dec_d = seg_of(d.john); // [R7] [R8]
    zero_blank_d = (d.john == `JC_ZERO) & ~filt_d[`PIN_RBI];
    d.carry = ~d.john[`JC_TOP_BIT]; // [R6]
    d.seg_c = dec_d[`SEG_C_IDX]; // [R10]
    if (ripple_mode) begin
      d.gate_o = 1'b0;
      d.rbo = ~zero_blank_d; // [R14]
      if (filt_d[`PIN_TEST]) begin
        d.seg = `SEG_ALL; // [R17]
      end else if (zero_blank_d) begin
        d.seg = `SEG_OFF; // [R12]
      end else begin
        d.seg = dec_d; // [R13]
      end
    end else begin
      d.gate_o = filt_d[`PIN_GATE]; // [R11]
      d.rbo = 1'b1;
      d.seg = filt_d[`PIN_GATE] ? dec_d : `SEG_OFF; // [R9]
    end

    // Write channel bookkeeping
    if (q.bvalid && axi_req_in.bready) begin
      d.bvalid = 1'b0;
    end
    if (aw_hs) begin
      d.aw_got = 1'b1;
      d.aw_addr = axi_req_in.awaddr;
    end
    if (w_hs) begin
      d.w_got = 1'b1;
      d.w_data = axi_req_in.wdata;
      d.w_strb = axi_req_in.wstrb;
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      // Only the control word is writable; the rest answer SLVERR
      if (wr_addr == `REG_CTRL) begin
        d.bresp = `RESP_OKAY;
        if (wr_strb[0]) begin
          d.ctrl = wr_data[`CTRL_W-1:0];
        end
      end else begin
        d.bresp = `RESP_SLVERR;
      end
    end

    // Read channel: data captured at the address handshake
    if (q.rvalid && axi_req_in.rready) begin
      d.rvalid = 1'b0;
    end
    if (ar_hs) begin
      d.rvalid = 1'b1;
      d.rdata = 32'h0;
      d.rresp = `RESP_OKAY;
      case (axi_req_in.araddr)
        `REG_CTRL: d.rdata[`CTRL_W-1:0] = q.ctrl;
        `REG_STATUS: begin
          d.rdata[`JC_W-1:0] = q.john;
          d.rdata[`ST_DIG_LSB +: 4] = jc_digit(q.john);
          d.rdata[`ST_CARRY_BIT] = q.carry;
          d.rdata[`ST_SEG_LSB +: 7] = seg_of(q.john);
        end
        `REG_SEGS: begin
          d.rdata[6:0] = q.seg;
          d.rdata[`SG_C_BIT] = q.seg_c;
          d.rdata[`SG_GATE_BIT] = q.gate_o;
          d.rdata[`SG_RBO_BIT] = q.rbo;
        end
        default: d.rresp = `RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset values match a zero count with every display input low
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= '0;
      q.carry <= 1'b1;
      q.rbo <= 1'b1;
      q.seg_c <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign seg_out = q.seg;
  assign seg_c_ungated_out = q.seg_c;
  assign display_gate_out = q.gate_o;
  assign ripple_blank_out = q.rbo;
  assign decade_carry_out = q.carry;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  property p_clear;
    clr_eff |=> (q.john == `JC_ZERO) && decade_carry_out;
  endproperty
  a_clear: assert property (p_clear) else $error("clear missed"); // [R1]

  property p_advance;
    cnt_edge && !inh_eff && !clr_eff && jc_legal(q.john)
      |=> q.john == jc_next($past(q.john));
  endproperty
  a_advance: assert property (p_advance) else $error("no advance"); // [R2]

  property p_hold;
    (!cnt_edge || inh_eff) && !clr_eff && jc_legal(q.john) |=> $stable(q.john);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved"); // [R3]

  property p_recover;
    !jc_legal(q.john) |=> q.john == `JC_ZERO;
  endproperty
  a_recover: assert property (p_recover) else $error("lockout"); // [R5]

  property p_carry;
    decade_carry_out == ~q.john[`JC_TOP_BIT];
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong"); // [R6]

  property p_gate_off;
    !ripple_mode && !q.filt[`PIN_GATE] && $stable(ripple_mode) |-> seg_out == `SEG_OFF;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate leak"); // [R9]

  property p_ungated_c;
    seg_c_ungated_out == seg_of(q.john)[`SEG_C_IDX];
  endproperty
  a_ungated_c: assert property (p_ungated_c) else $error("ungated c"); // [R10]

  property p_gate_follow;
    !ripple_mode && $stable(ripple_mode) |-> display_gate_out == q.filt[`PIN_GATE];
  endproperty
  a_gate_follow: assert property (p_gate_follow) else $error("gate out"); // [R11]

  property p_blank;
    ripple_mode && $stable(ripple_mode) && !q.filt[`PIN_TEST]
      && q.john == `JC_ZERO && !q.filt[`PIN_RBI] |-> seg_out == `SEG_OFF;
  endproperty
  a_blank: assert property (p_blank) else $error("zero shown"); // [R12]

  property p_show_zero;
    ripple_mode && $stable(ripple_mode) && !q.filt[`PIN_TEST]
      && q.john == `JC_ZERO && q.filt[`PIN_RBI] |-> seg_out == `SEG_D0;
  endproperty
  a_show_zero: assert property (p_show_zero) else $error("zero blank"); // [R13]

  property p_rbo;
    ripple_mode && $stable(ripple_mode)
      |-> ripple_blank_out == !(q.john == `JC_ZERO && !q.filt[`PIN_RBI]);
  endproperty
  a_rbo: assert property (p_rbo) else $error("blank out"); // [R14]

  property p_test;
    ripple_mode && $stable(ripple_mode) && q.filt[`PIN_TEST] |-> seg_out == `SEG_ALL;
  endproperty
  a_test: assert property (p_test) else $error("test fail"); // [R17]

  property p_decode;
    ripple_mode && $stable(ripple_mode) && !q.filt[`PIN_TEST]
      && q.john != `JC_ZERO |-> seg_out == seg_of(q.john);
  endproperty
  a_decode: assert property (p_decode) else $error("bad digit"); // [R7]

  // Main scenarios
  c_wrap: cover property (q.john == 5'h10 ##1 q.john == `JC_ZERO);
  c_test: cover property (ripple_mode && seg_out == `SEG_ALL);
  c_blank: cover property (ripple_mode && !ripple_blank_out);
  c_write: cover property (wr_fire && wr_addr == `REG_CTRL);

endmodule : decade_counter_seven_segment

// ==== testbench/display_far_side.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Display digit and next decade
// ----------------------------------------
module display_far_side
  import dc7_pkg::*;
(
  input wire logic sys_rst_in,
  input wire logic [6:0] seg_in,
  input wire logic carry_in,
  output logic [3:0] digit_out,
  output logic [7:0] next_count_out
);
  // Lit pattern back to a digit, f when nothing valid is lit
  always_comb begin
    case (seg_in)
      7'h3f: digit_out = 4'h0;
      7'h06: digit_out = 4'h1;
      7'h5b: digit_out = 4'h2;
      7'h4f: digit_out = 4'h3;
      7'h66: digit_out = 4'h4;
      7'h6d: digit_out = 4'h5;
      7'h7d: digit_out = 4'h6;
      7'h07: digit_out = 4'h7;
      7'h7f: digit_out = 4'h8;
      7'h6f: digit_out = 4'h9;
      default: digit_out = 4'hf;
    endcase
  end

  // Next decade clocked straight off the carry line
  always_ff @(posedge carry_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      next_count_out <= 8'h00;
    end else begin
      next_count_out <= next_count_out + 8'h01;
    end
  end
endmodule : display_far_side

// ==== testbench/decade_counter_seven_segment_tb.sv ====
`timescale 1ns/1ps
module decade_counter_seven_segment_tb
  import dc7_pkg::*;
;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic cclk = 1'b0, inh = 1'b0, crst = 1'b0, gate = 1'b1, rbi = 1'b0, tst = 1'b0;
  logic [6:0] seg;
  logic segc, gate_o, rbo, carry;
  logic [3:0] digit;
  logic [7:0] nxt;
  logic [31:0] d;
  int miscompares = 0, cmp_count = 0, cycles = 0, i;
  logic [6:0] tbl [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
                           7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};

  always #4 mclk_in = ~mclk_in;

  decade_counter_seven_segment dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .axi_req_in(req), .axi_rsp_out(rsp), .count_clk_in(cclk), .count_inhibit_in(inh),
    .count_reset_in(crst), .display_gate_in(gate), .ripple_blank_in(rbi),
    .segment_test_in(tst), .seg_out(seg), .seg_c_ungated_out(segc),
    .display_gate_out(gate_o), .ripple_blank_out(rbo), .decade_carry_out(carry));

  display_far_side far_u (.sys_rst_in(sys_rst_in), .seg_in(seg), .carry_in(carry),
    .digit_out(digit), .next_count_out(nxt));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // Pins pass a three-flop filter, so wait past it
  task settle;
    repeat (5) @(posedge mclk_in);
  endtask : settle

  task pulse;
    @(posedge mclk_in);
    cclk <= 1'b1;
    repeat (4) @(posedge mclk_in);
    cclk <= 1'b0;
    repeat (4) @(posedge mclk_in);
  endtask : pulse

  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge mclk_in);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= v;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    // Each channel drops valid once taken; only the timeout ends a stuck wait
    @(posedge mclk_in);
    while (!rsp.bvalid) begin
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      @(posedge mclk_in);
    end
    chk(rsp.bresp, er);
    req.bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    @(posedge mclk_in);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    @(posedge mclk_in);
    while (!rsp.rvalid) begin
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      @(posedge mclk_in);
    end
    v = rsp.rdata;
    chk(rsp.rresp, er);
    req.rready <= 1'b0;
  endtask : rd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_count;
    chk(seg, tbl[0]);
    for (i = 1; i <= 10; i++) begin
      pulse();
      chk(seg, tbl[i % 10]);
      chk(digit, i % 10);
      chk(carry, (i % 10) < 5);
    end
    chk(nxt, 8'h01);
    $display("test count done");
  endtask : t_count

  // Pin inhibit then soft inhibit, each across a clock edge
  task t_inhibit;
    inh <= 1'b1;
    settle();
    pulse();
    chk(seg, tbl[0]);
    inh <= 1'b0;
    wr(8'h00, 32'h2, 2'h0);
    pulse();
    chk(seg, tbl[0]);
    wr(8'h00, 32'h0, 2'h0);
    pulse();
    chk(seg, tbl[1]);
    $display("test inhibit done");
  endtask : t_inhibit

  task t_gate;
    gate <= 1'b0;
    settle();
    chk(seg, 7'h00);
    chk(gate_o, 1'b0);
    chk(segc, 1'b1);
    pulse();
    chk(segc, tbl[2][2]);
    chk(seg, 7'h00);
    chk(carry, 1'b1);
    gate <= 1'b1;
    settle();
    chk(seg, tbl[2]);
    chk(gate_o, 1'b1);
    $display("test gate done");
  endtask : t_gate

  task t_bus;
    rd(8'h04, 2'h0, d);
    chk(d[11:8], 4'h2);
    rd(8'h0c, 2'h2, d);
    chk(d, 32'h0);
    wr(8'h04, 32'h0, 2'h2);
    wr(8'h00, 32'h4, 2'h0);
    rd(8'h00, 2'h0, d);
    chk(d, 32'h4);
    settle();
    chk(seg, tbl[0]);
    wr(8'h00, 32'h0, 2'h0);
    pulse();
    crst <= 1'b1;
    settle();
    chk(seg, tbl[0]);
    pulse();
    chk(seg, tbl[0]);
    crst <= 1'b0;
    settle();
    $display("test bus done");
  endtask : t_bus

  // Most significant digit with blank-in tied low
  task t_ripple;
    wr(8'h00, 32'h1, 2'h0);
    rbi <= 1'b0;
    settle();
    chk(seg, 7'h00);
    chk(rbo, 1'b0);
    tst <= 1'b1;
    settle();
    chk(seg, 7'h7f);
    tst <= 1'b0;
    rbi <= 1'b1;
    settle();
    chk(seg, tbl[0]);
    chk(rbo, 1'b1);
    // Now the least significant fraction digit, blank-in tied low
    rbi <= 1'b0;
    pulse();
    chk(seg, tbl[1]);
    chk(rbo, 1'b1);
    $display("test ripple done");
  endtask : t_ripple

  // Whole run is well under two thousand cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    settle();
    t_count();
    t_inhibit();
    t_gate();
    t_bus();
    t_ripple();
    close_out();
  end
endmodule : decade_counter_seven_segment_tb
